/* gpio_port_defines.svh */
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// Register indices; the AXI byte address is four times the index
`define IDX_WIDE_DATA 16'hFFC4
`define IDX_NARROW_DATA 16'hFFC5
`define IDX_WIDE_DIR 16'hFFD4
`define IDX_NARROW_DIR 16'hFFD5
`define IDX_WIDE_FSEL 16'hFFDB
`define IDX_NARROW_FSEL 16'hFFDC
`define IDX_ALT_CTRL 16'hFFE0

// Reset values
`define RST_WIDE_DIR 8'h00
`define RST_WIDE_DATA 8'h00
`define RST_WIDE_FSEL 8'hFE
`define RST_NARROW_DIR 8'hF0
`define RST_NARROW_DATA 8'hF0
`define RST_NARROW_FSEL 8'hF1
`define RST_ALT_CTRL 8'h00

// Bits that always read as one; all but the direction read value also ignore writes
`define MASK_WIDE_FSEL 8'hFE
`define MASK_NARROW_FSEL 8'hF1
`define MASK_NARROW_UPPER 8'hF0
`define MASK_ALT_CTRL 8'h00
`define DIR_READ_VALUE 8'hFF

// Field positions
`define BIT_PWM_SELECT 0
`define BIT_RT_REALTIME_OUTPUT_TRIGGER_IN_SELECT 3
`define BIT_EVENT_SELECT 2
`define BIT_EVENT_EDGE 1
`define BIT_CMP_A_ENABLE 0
`define BIT_CMP_B_ENABLE 1
`define BIT_REALTIME_OUTPUT_TRIGGER_IN_SEL_LOW 2
`define BIT_REALTIME_OUTPUT_TRIGGER_IN_SEL_HIGH 3

// Pin positions
`define PIN_PWM 0
`define PIN_CMP_A 5
`define PIN_CMP_B 6
`define PIN_RT_REALTIME_OUTPUT_TRIGGER_IN 3
`define PIN_EVENT 2
`define PIN_CONV_REALTIME_OUTPUT_TRIGGER_IN 0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* gpio_port_pkg.sv */
package gpio_port_pkg;

  // Chip power state, driven by the system controller on clk
  typedef enum logic [2:0] {
    PM_ACTIVE,
    PM_SLEEP,
    PM_STANDBY,
    PM_WATCH,
    PM_SUBACTIVE,
    PM_SUBSLEEP
  } power_mode_t;

  // Drive of the eight-pin port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } wide_drive_t;

  // Drive of the four-pin port
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } narrow_drive_t;

  // Alternate outputs coming from the timers
  typedef struct packed {
    logic compare_output_b;
    logic compare_output_a;
    logic fourteen_bit_pwm_out;
  } timer_out_t;

  // Capture inputs handed to the timer
  typedef struct packed {
    logic capture_input_d;
    logic capture_input_c;
    logic capture_input_b;
    logic capture_input_a;
  } capture_t;

  // Alternate inputs of the four-pin port
  typedef struct packed {
    logic realtime_output_trigger_in;
    logic timer_b_event_in;
    logic timer_b_event_edge;
    logic conversion_start_trigger_in;
  } narrow_alt_t;

endpackage

/* dual_io_port_pin_mux.sv */
// Summary of operation
// RULE1: Wide direction bit one drives, zero inputs
// RULE2: Direction and latch act only in general mode
// RULE3: Wide direction register reads back all ones
// RULE4: Reset clears wide direction and data latch
// RULE5: Output pin reads return the data latch
// RULE6: Input pin reads return the synchronised pin
// RULE7: Pin six drives compare B when enabled
// RULE8: Pin five drives compare A when enabled
// RULE9: Pin seven follows only its direction bit
// RULE10: Pins four to one always feed captures
// RULE11: Pin zero carries PWM when selected
// RULE12: Pins float in reset, standby, watch; hold sleeping
// RULE13: Board keeps capture pins at valid levels
// RULE14: Narrow port has four pins, three to zero
// RULE15: Narrow resets: select F1, direction/data F0
// RULE16: Narrow select upper bits read one, ignore writes
// RULE17: Select bit three makes pin three trigger
// RULE18: Select bit two makes pin two event input
// RULE19: Select bit one picks event edge polarity
// RULE20: Narrow pin zero chosen by trigger select bits
// RULE21: Trigger select eleven makes conversion start input
// RULE22: Narrow direction write-only, reads ones, one drives
// RULE23: Narrow reads: output latch, input pin level
// RULE24: Driver on for alternate output or output direction
// RULE25: Pin levels pass two flops before use
`timescale 1ns/10ps
`include "gpio_port_defines.svh"
`default_nettype none

module dual_io_port_pin_mux #(
  parameter int ADDR_W = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // System side
  input wire gpio_port_pkg::power_mode_t power_mode,
  input wire gpio_port_pkg::timer_out_t timer_out,
  output gpio_port_pkg::capture_t capture,
  output gpio_port_pkg::narrow_alt_t narrow_alt,
  // Pins
  input wire logic [7:0] wide_pin_in,
  output gpio_port_pkg::wide_drive_t wide_pins,
  input wire logic [3:0] narrow_pin_in,
  output gpio_port_pkg::narrow_drive_t narrow_pins
);
  import gpio_port_pkg::*;

  localparam int WA = ADDR_W - 2;

  // Software-visible registers, reserved bits stored as ones
  logic [7:0] wide_port_direction;
  logic [7:0] wide_port_data;
  logic [7:0] wide_port_function_select;
  logic [7:0] narrow_port_direction;
  logic [7:0] narrow_port_data;
  logic [7:0] narrow_port_function_select;
  logic [7:0] alt_control;
  logic [7:0] next_wide_port_direction;
  logic [7:0] next_wide_port_data;
  logic [7:0] next_wide_port_function_select;
  logic [7:0] next_narrow_port_direction;
  logic [7:0] next_narrow_port_data;
  logic [7:0] next_narrow_port_function_select;
  logic [7:0] next_alt_control;

  // Bus channel state
  logic aw_full;
  logic [WA-1:0] aw_word;
  logic w_full;
  logic [7:0] w_byte;
  logic w_lane0;
  logic next_aw_full;
  logic [WA-1:0] next_aw_word;
  logic next_w_full;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;

  // Synchronisers; the meta stage feeds only the sync stage
  logic [7:0] wide_meta;
  logic [7:0] wide_sync;
  logic [3:0] narrow_meta;
  logic [3:0] narrow_sync;
  logic event_prev;

  // Pin drive and alternate input next values
  wide_drive_t next_wide_pins;
  narrow_drive_t next_narrow_pins;
  capture_t next_capture;
  narrow_alt_t next_narrow_alt;

  // Decoded selections
  logic pwm_sel;
  logic cmp_a_sel;
  logic cmp_b_sel;
  logic rt_sel;
  logic event_sel;
  logic edge_rising;
  logic conv_sel;
  logic [7:0] wide_alt_sel;
  logic [7:0] wide_alt_val;
  logic [3:0] narrow_in_sel;

  assign pwm_sel = wide_port_function_select[`BIT_PWM_SELECT];
  assign cmp_a_sel = alt_control[`BIT_CMP_A_ENABLE];
  assign cmp_b_sel = alt_control[`BIT_CMP_B_ENABLE];
  assign rt_sel = narrow_port_function_select[`BIT_RT_REALTIME_OUTPUT_TRIGGER_IN_SELECT];
  assign event_sel = narrow_port_function_select[`BIT_EVENT_SELECT];
  assign edge_rising = narrow_port_function_select[`BIT_EVENT_EDGE];
  // Pin zero of the narrow port is steered by the trigger select pair only
  assign conv_sel = alt_control[`BIT_REALTIME_OUTPUT_TRIGGER_IN_SEL_HIGH] & alt_control[`BIT_REALTIME_OUTPUT_TRIGGER_IN_SEL_LOW]; // RULE20 RULE21

  // Handshake readies are combinational from channel state
  assign awready = !aw_full;
  assign wready = !w_full;
  assign arready = !rvalid;

  // Read mux: returns response and low byte of the addressed register
  function automatic logic [9:0] read_reg(input logic [WA-1:0] word);
    logic [9:0] res;
    res = {`RESP_OKAY, 8'h00};
    if (word == WA'(`IDX_WIDE_DIR)) begin
      res[7:0] = `DIR_READ_VALUE; // RULE3
    end else if (word == WA'(`IDX_NARROW_DIR)) begin
      res[7:0] = `DIR_READ_VALUE; // RULE22
    end else if (word == WA'(`IDX_WIDE_DATA)) begin
      // Output pins show the latch, input pins the synchronised level
      res[7:0] = (wide_port_direction & wide_port_data) | (~wide_port_direction & wide_sync); // RULE5 RULE6
    end else if (word == WA'(`IDX_NARROW_DATA)) begin
      res[7:0] = `MASK_NARROW_UPPER |
                 {4'h0, (narrow_port_direction[3:0] & narrow_port_data[3:0]) |
                        (~narrow_port_direction[3:0] & narrow_sync)}; // RULE23
    end else if (word == WA'(`IDX_WIDE_FSEL)) begin
      res[7:0] = wide_port_function_select;
    end else if (word == WA'(`IDX_NARROW_FSEL)) begin
      res[7:0] = narrow_port_function_select; // RULE16
    end else if (word == WA'(`IDX_ALT_CTRL)) begin
      res[7:0] = alt_control;
    end else begin
      res = {`RESP_SLVERR, 8'h00};
    end
    return res;
  endfunction

  // Next state of the bus slave and the register file
  always_comb begin
    logic [9:0] rd;
    rd = read_reg(araddr[ADDR_W-1:2]);
    next_wide_port_direction = wide_port_direction;
    next_wide_port_data = wide_port_data;
    next_wide_port_function_select = wide_port_function_select;
    next_narrow_port_direction = narrow_port_direction;
    next_narrow_port_data = narrow_port_data;
    next_narrow_port_function_select = narrow_port_function_select;
    next_alt_control = alt_control;
    next_aw_full = aw_full;
    next_aw_word = aw_word;
    next_w_full = w_full;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bresp = bresp;
    next_bvalid = bvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_rvalid = rvalid;
    // Address and data are caught independently, in either order
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_aw_word = awaddr[ADDR_W-1:2];
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane0 = wstrb[0];
    end
    // Commit once both halves are held and no response is pending
    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      if (aw_word == WA'(`IDX_WIDE_DIR)) begin
        if (w_lane0) begin
          next_wide_port_direction = w_byte; // RULE1
        end
      end else if (aw_word == WA'(`IDX_WIDE_DATA)) begin
        if (w_lane0) begin
          next_wide_port_data = w_byte;
        end
      end else if (aw_word == WA'(`IDX_WIDE_FSEL)) begin
        if (w_lane0) begin
          next_wide_port_function_select = w_byte | `MASK_WIDE_FSEL;
        end
      end else if (aw_word == WA'(`IDX_NARROW_DIR)) begin
        if (w_lane0) begin
          next_narrow_port_direction = w_byte | `MASK_NARROW_UPPER; // RULE14 RULE22
        end
      end else if (aw_word == WA'(`IDX_NARROW_DATA)) begin
        if (w_lane0) begin
          next_narrow_port_data = w_byte | `MASK_NARROW_UPPER; // RULE14
        end
      end else if (aw_word == WA'(`IDX_NARROW_FSEL)) begin
        if (w_lane0) begin
          next_narrow_port_function_select = w_byte | `MASK_NARROW_FSEL; // RULE16
        end
      end else if (aw_word == WA'(`IDX_ALT_CTRL)) begin
        if (w_lane0) begin
          next_alt_control = w_byte | `MASK_ALT_CTRL;
        end
      end else begin
        next_bresp = `RESP_SLVERR;
      end
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // Read data is captured at the address handshake
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rd[7:0]};
      next_rresp = rd[9:8];
    end
  end

  // Register stage of the bus slave and register file
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wide_port_direction <= `RST_WIDE_DIR; // RULE4
      wide_port_data <= `RST_WIDE_DATA; // RULE4
      wide_port_function_select <= `RST_WIDE_FSEL;
      narrow_port_direction <= `RST_NARROW_DIR; // RULE15
      narrow_port_data <= `RST_NARROW_DATA; // RULE15
      narrow_port_function_select <= `RST_NARROW_FSEL; // RULE15
      alt_control <= `RST_ALT_CTRL;
      aw_full <= 1'b0;
      aw_word <= '0;
      w_full <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bresp <= `RESP_OKAY;
      bvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
      rvalid <= 1'b0;
    end else begin
      wide_port_direction <= next_wide_port_direction;
      wide_port_data <= next_wide_port_data;
      wide_port_function_select <= next_wide_port_function_select;
      narrow_port_direction <= next_narrow_port_direction;
      narrow_port_data <= next_narrow_port_data;
      narrow_port_function_select <= next_narrow_port_function_select;
      alt_control <= next_alt_control;
      aw_full <= next_aw_full;
      aw_word <= next_aw_word;
      w_full <= next_w_full;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bresp <= next_bresp;
      bvalid <= next_bvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      rvalid <= next_rvalid;
    end
  end

  // Pin synchronisers; costs two cycles of input latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wide_meta <= 8'h00;
      wide_sync <= 8'h00;
      narrow_meta <= 4'h0;
      narrow_sync <= 4'h0;
      event_prev <= 1'b0;
    end else begin
      wide_meta <= wide_pin_in; // RULE25
      wide_sync <= wide_meta;
      narrow_meta <= narrow_pin_in; // RULE25
      narrow_sync <= narrow_meta;
      event_prev <= narrow_sync[`PIN_EVENT];
    end
  end

  // Next pin drive and alternate inputs
  always_comb begin
    wide_alt_sel = 8'h00;
    wide_alt_val = 8'h00;
    wide_alt_sel[`PIN_PWM] = pwm_sel; // RULE11
    wide_alt_val[`PIN_PWM] = timer_out.fourteen_bit_pwm_out;
    wide_alt_sel[`PIN_CMP_A] = cmp_a_sel; // RULE8
    wide_alt_val[`PIN_CMP_A] = timer_out.compare_output_a;
    wide_alt_sel[`PIN_CMP_B] = cmp_b_sel; // RULE7
    wide_alt_val[`PIN_CMP_B] = timer_out.compare_output_b;
    narrow_in_sel = 4'h0;
    narrow_in_sel[`PIN_RT_REALTIME_OUTPUT_TRIGGER_IN] = rt_sel; // RULE17
    narrow_in_sel[`PIN_EVENT] = event_sel; // RULE18
    narrow_in_sel[`PIN_CONV_REALTIME_OUTPUT_TRIGGER_IN] = conv_sel; // RULE21
    // Pin seven and pins four to one have no alternate output
    next_wide_pins.oe = wide_alt_sel | wide_port_direction; // RULE2 RULE9 RULE24
    next_wide_pins.out = (wide_alt_sel & wide_alt_val) | (~wide_alt_sel & wide_port_data); // RULE2
    next_narrow_pins.oe = ~narrow_in_sel & narrow_port_direction[3:0]; // RULE2 RULE24
    next_narrow_pins.out = narrow_port_data[3:0];
    case (power_mode)
      PM_ACTIVE, PM_SUBACTIVE: begin
        // Normal operation
      end
      PM_SLEEP, PM_SUBSLEEP: begin
        // Hold the last drive while the core sleeps
        next_wide_pins = wide_pins; // RULE12
        next_narrow_pins = narrow_pins;
      end
      default: begin
        // Standby and watch release every driver
        next_wide_pins = '0; // RULE12
        next_narrow_pins = '0;
      end
    endcase
    // Captures track the pins whatever the direction
    next_capture.capture_input_d = wide_sync[4]; // RULE10
    next_capture.capture_input_c = wide_sync[3];
    next_capture.capture_input_b = wide_sync[2];
    next_capture.capture_input_a = wide_sync[1];
    // Deselected inputs idle low so the consumers see no edges
    next_narrow_alt.realtime_output_trigger_in = rt_sel & narrow_sync[`PIN_RT_REALTIME_OUTPUT_TRIGGER_IN];
    next_narrow_alt.timer_b_event_in = event_sel & narrow_sync[`PIN_EVENT];
    next_narrow_alt.timer_b_event_edge = event_sel &
      (edge_rising ? (narrow_sync[`PIN_EVENT] & ~event_prev)
                   : (~narrow_sync[`PIN_EVENT] & event_prev)); // RULE19
    next_narrow_alt.conversion_start_trigger_in = conv_sel & narrow_sync[`PIN_CONV_REALTIME_OUTPUT_TRIGGER_IN];
  end

  // Register stage of pin drive; reset leaves every pin floating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wide_pins <= '0; // RULE12
      narrow_pins <= '0;
      capture <= '0;
      narrow_alt <= '0;
    end else begin
      wide_pins <= next_wide_pins;
      narrow_pins <= next_narrow_pins;
      capture <= next_capture;
      narrow_alt <= next_narrow_alt;
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic running;
  assign running = (power_mode == PM_ACTIVE) || (power_mode == PM_SUBACTIVE);

  sequence s_ar_dir;
    arvalid && arready &&
      (araddr[ADDR_W-1:2] == WA'(`IDX_WIDE_DIR) || araddr[ADDR_W-1:2] == WA'(`IDX_NARROW_DIR));
  endsequence
  sequence s_read_answer_ones;
    rvalid && rdata == 32'h000000FF;
  endsequence

  property p_dir_reads_ones;
    s_ar_dir |=> s_read_answer_ones;
  endproperty
  a_dir_reads_ones: assert property (p_dir_reads_ones) else $error("direction read not all ones"); // RULE3

  property p_reset_clears;
    @(posedge clk) disable iff (1'b0)
      !rst_n |=> wide_port_direction == 8'h00 && wide_port_data == 8'h00 &&
                 narrow_port_function_select == 8'hF1 && narrow_pins.oe == 4'h0;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset values wrong"); // RULE4

  property p_pin7_plain;
    running |=> wide_pins.oe[7] == $past(wide_port_direction[7]) &&
                wide_pins.out[7] == $past(wide_port_data[7]);
  endproperty
  a_pin7_plain: assert property (p_pin7_plain) else $error("pin 7 drive wrong"); // RULE9

  property p_cmp_b;
    running && cmp_b_sel |=> wide_pins.oe[6] && wide_pins.out[6] == $past(timer_out.compare_output_b);
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("compare B not on pin 6"); // RULE7

  property p_cmp_a;
    running && cmp_a_sel |=> wide_pins.oe[5] && wide_pins.out[5] == $past(timer_out.compare_output_a);
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("compare A not on pin 5"); // RULE8

  property p_pwm;
    running && pwm_sel |=>
      wide_pins.oe[0] && wide_pins.out[0] == $past(timer_out.fourteen_bit_pwm_out);
  endproperty
  a_pwm: assert property (p_pwm) else $error("PWM not on pin 0"); // RULE11

  property p_float_standby;
    (power_mode == PM_STANDBY || power_mode == PM_WATCH) |=>
      wide_pins.oe == 8'h00 && narrow_pins.oe == 4'h0;
  endproperty
  a_float_standby: assert property (p_float_standby) else $error("driver on in standby"); // RULE12

  property p_hold_sleep;
    (power_mode == PM_SLEEP || power_mode == PM_SUBSLEEP) |=>
      $stable(wide_pins) && $stable(narrow_pins);
  endproperty
  a_hold_sleep: assert property (p_hold_sleep) else $error("pins moved in sleep"); // RULE12

  property p_capture_path;
    ##3 capture.capture_input_a == $past(wide_pin_in[1], 3) &&
        capture.capture_input_d == $past(wide_pin_in[4], 3);
  endproperty
  a_capture_path: assert property (p_capture_path) else $error("capture not fed from pin"); // RULE10

  property p_conv_input;
    running && conv_sel |=> !narrow_pins.oe[0];
  endproperty
  a_conv_input: assert property (p_conv_input) else $error("pin 0 driven as trigger"); // RULE21

  property p_event_edge;
    event_sel && edge_rising && narrow_sync[2] && !event_prev |=> narrow_alt.timer_b_event_edge;
  endproperty
  a_event_edge: assert property (p_event_edge) else $error("rising event lost"); // RULE19

  property p_fsel_reserved;
    arvalid && arready && araddr[ADDR_W-1:2] == WA'(`IDX_NARROW_FSEL) |=>
      rdata[7:4] == 4'hF && rdata[0];
  endproperty
  a_fsel_reserved: assert property (p_fsel_reserved) else $error("reserved bits not one"); // RULE16

endmodule

`default_nettype wire

/* gpio_board_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Board side of both ports: a driven pin shows the device level,
// a released pin shows what the board applies
module gpio_board_model (
  input wire gpio_port_pkg::wide_drive_t wide_pins,
  input wire gpio_port_pkg::narrow_drive_t narrow_pins,
  input wire logic [7:0] wide_level,
  input wire logic [3:0] narrow_level,
  output logic [7:0] wide_pin_in,
  output logic [3:0] narrow_pin_in
);
  import gpio_port_pkg::*;
  // Board levels are always a clean high or low, never in between
  assign wide_pin_in = (wide_pins.oe & wide_pins.out) | (~wide_pins.oe & wide_level);
  // Device drive wins over the board's weak source
  assign narrow_pin_in = (narrow_pins.oe & narrow_pins.out) | (~narrow_pins.oe & narrow_level);
endmodule

`default_nettype wire

/* dual_io_port_pin_mux_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_port_defines.svh"

module dual_io_port_pin_mux_tb;
  import gpio_port_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [17:0] awaddr = 0;
  logic awvalid = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  // Lane strobe that the next write offers
  logic [3:0] wr_strb = 4'hF;
  logic wvalid = 0;
  logic bready = 0;
  logic [17:0] araddr = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  power_mode_t power_mode = PM_ACTIVE;
  timer_out_t timer_out = '0;
  capture_t capture;
  narrow_alt_t narrow_alt;
  logic [7:0] wide_pin_in, ext_wide = 8'h00;
  logic [3:0] narrow_pin_in, ext_narrow = 4'h0;
  wide_drive_t wide_pins;
  narrow_drive_t narrow_pins;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Power modes in the order the pins are walked through them
  power_mode_t modes [7] = '{PM_ACTIVE, PM_SLEEP, PM_SUBACTIVE, PM_SUBSLEEP,
    PM_STANDBY, PM_WATCH, PM_ACTIVE};

  // Clock at 250 MHz
  always #2 clk = ~clk;

  dual_io_port_pin_mux #(.ADDR_W(18)) dual_io_port_pin_mux_inst (
    .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .power_mode(power_mode), .timer_out(timer_out), .capture(capture),
    .narrow_alt(narrow_alt), .wide_pin_in(wide_pin_in), .wide_pins(wide_pins),
    .narrow_pin_in(narrow_pin_in), .narrow_pins(narrow_pins));

  gpio_board_model gpio_board_model_inst (
    .wide_pins(wide_pins), .narrow_pins(narrow_pins), .wide_level(ext_wide),
    .narrow_level(ext_narrow), .wide_pin_in(wide_pin_in), .narrow_pin_in(narrow_pin_in));

  // Verdict and end of run, reached from the sequence or the watchdog
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a;
    logic w;
    a = 0;
    w = 0;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    awvalid <= 1;
    wdata <= {24'h0, d};
    wstrb <= wr_strb;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (!a && awready === 1'b1) begin
        awvalid <= 0;
        a = 1;
      end
      if (!w && wready === 1'b1) begin
        wvalid <= 0;
        w = 1;
      end
    end while (!(a && w));
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 0;
    chk({38'h0, bresp}, {38'h0, er});
  endtask

  // Read: data and response taken at the edge where rvalid is seen
  task automatic rd(input logic [15:0] idx, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 0;
    chk({6'h0, rresp, rdata}, {6'h0, er, 24'h0, ed});
  endtask

  // Count event pulses in a window after moving event pin two
  task automatic pulses(input logic lv, output int n);
    ext_narrow[2] <= lv;
    n = 0;
    repeat (10) begin
      @(posedge clk);
      if (narrow_alt.timer_b_event_edge === 1'b1) n++;
    end
  endtask

  initial begin
    int n;
    logic [7:0] eoe;
    logic [7:0] eout;
    timer_out_t t;
    wt(4);
    chk({28'h0, wide_pins.oe, narrow_pins.oe}, 40'h0);
    rst_n <= 1;
    wt(4);
    chk({28'h0, wide_pins.oe, narrow_pins.oe}, 40'h0);
    rd(`IDX_WIDE_DIR, 8'hFF, `RESP_OKAY);
    rd(`IDX_WIDE_DATA, 8'h00, `RESP_OKAY);
    rd(`IDX_WIDE_FSEL, 8'hFE, `RESP_OKAY);
    rd(`IDX_NARROW_DIR, 8'hFF, `RESP_OKAY);
    rd(`IDX_NARROW_DATA, 8'hF0, `RESP_OKAY);
    rd(`IDX_NARROW_FSEL, 8'hF1, `RESP_OKAY);
    // Unmapped place refuses both ways
    wr(16'hFFF0, 8'h5A, `RESP_SLVERR);
    rd(16'hFFF0, 8'h00, `RESP_SLVERR);
    // Mixed directions; pin four drives low against a high board level
    ext_wide <= 8'h3C;
    wr(`IDX_WIDE_DIR, 8'h90, `RESP_OKAY);
    wr(`IDX_WIDE_DATA, 8'hA5, `RESP_OKAY);
    wt(6);
    chk({24'h0, wide_pins.oe, wide_pins.out & 8'h90}, {24'h0, 8'h90, 8'h80});
    chk({36'h0, capture}, 40'h6);
    rd(`IDX_WIDE_DATA, 8'hAC, `RESP_OKAY);
    // A write with lane zero off is answered but leaves the latch alone
    wr_strb = 4'h0;
    wr(`IDX_WIDE_DATA, 8'h00, `RESP_OKAY);
    wr_strb = 4'hF;
    rd(`IDX_WIDE_DATA, 8'hAC, `RESP_OKAY);
    rd(`IDX_WIDE_DIR, 8'hFF, `RESP_OKAY);
    // Alternate outputs take pins five, six and zero over the direction bits
    wr(`IDX_ALT_CTRL, 8'h03, `RESP_OKAY);
    wr(`IDX_WIDE_FSEL, 8'h01, `RESP_OKAY);
    rd(`IDX_WIDE_FSEL, 8'hFF, `RESP_OKAY);
    t = 3'b101;
    eoe = 8'hF1;
    eout = 8'hC1;
    // Walk the power modes, moving the timer outputs at every step
    for (int i = 0; i < 7; i++) begin
      t = i[0] ? 3'b010 : 3'b101;
      power_mode <= modes[i];
      timer_out <= t;
      wt(4);
      case (modes[i])
        PM_STANDBY, PM_WATCH: eoe = 8'h00;
        PM_SLEEP, PM_SUBSLEEP: ;
        default: begin
          eoe = 8'hF1;
          eout = t[0] ? 8'hC1 : 8'hA0;
        end
      endcase
      chk({24'h0, wide_pins.oe, wide_pins.out & eoe}, {24'h0, eoe, eout & eoe});
    end
    // Pin seven follows its direction bit alone
    wr(`IDX_WIDE_DIR, 8'h10, `RESP_OKAY);
    wt(4);
    chk({32'h0, wide_pins.oe}, 40'h71);
    wr(`IDX_WIDE_FSEL, 8'h00, `RESP_OKAY);
    rd(`IDX_WIDE_FSEL, 8'hFE, `RESP_OKAY);
    // Narrow port as plain I/O
    ext_narrow <= 4'h5;
    wr(`IDX_NARROW_FSEL, 8'h00, `RESP_OKAY);
    rd(`IDX_NARROW_FSEL, 8'hF1, `RESP_OKAY);
    wr(`IDX_NARROW_DIR, 8'h0F, `RESP_OKAY);
    wr(`IDX_NARROW_DATA, 8'h0A, `RESP_OKAY);
    wt(4);
    chk({32'h0, narrow_pins}, 40'hAF);
    rd(`IDX_NARROW_DATA, 8'hFA, `RESP_OKAY);
    wr(`IDX_NARROW_DIR, 8'h00, `RESP_OKAY);
    wt(4);
    rd(`IDX_NARROW_DATA, 8'hF5, `RESP_OKAY);
    // Trigger and event inputs release their pins
    wr(`IDX_NARROW_DIR, 8'h0F, `RESP_OKAY);
    ext_narrow <= 4'hD;
    wr(`IDX_NARROW_FSEL, 8'h0C, `RESP_OKAY);
    rd(`IDX_NARROW_FSEL, 8'hFD, `RESP_OKAY);
    wr(`IDX_ALT_CTRL, 8'h0C, `RESP_OKAY);
    wt(6);
    chk({36'h0, narrow_pins.oe}, 40'h2);
    chk({36'h0, narrow_alt}, 40'hD);
    // One trigger select bit alone leaves pin zero plain
    wr(`IDX_ALT_CTRL, 8'h04, `RESP_OKAY);
    wt(6);
    chk({38'h0, narrow_pins.oe[0], narrow_alt.conversion_start_trigger_in}, 40'h2);
    // Edge polarity: one pulse on the chosen edge, none on the other
    for (int e = 0; e < 2; e++) begin
      wr(`IDX_NARROW_FSEL, 8'h04 | 8'(e << 1), `RESP_OKAY);
      ext_narrow[2] <= ~e[0];
      wt(8);
      pulses(e[0], n);
      chk(40'(n), 40'h1);
      pulses(~e[0], n);
      chk(40'(n), 40'h0);
    end
    end_sim();
  end
endmodule

`default_nettype wire
